// ===== core/mbc_basic_config.v
// Purpose: Per-channel basic motor configuration for a 16-channel
//          stepping motor controller, driven from a Wishbone slave
// Assumes: Command parser upstream turns ASCII commands into register
//          writes; motor_moving and remote_mode come from sys_clk logic
// Notes:   No reply is produced for set or hold-off switch writes
//
// Summary of operation
// - Set: channel, enable, hold-off, accel, pulse; silent
// - Enable zero forces both limits, inhibiting motion
// - Mode 0 drives hold-off while stopped; mode 1 never
// - Mode 2 holds while running; mode 3 always
// - Modes 2, 3 invert output polarity
// - Accel field: constant, trapezoid, S-shaped
// - Pulse field: CW/CCW or two pulse-direction kinds
// - Query returns enable, hold-off, accel, pulse digits
// - Hold switch: ON disables, OFF enables; silent
// - Switch and set share one hold-off setting
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "mbc_consts.vh"

module mbc_basic_config #(
   parameter CHANNELS = 16,
   parameter CH_BITS  = 4
) (
   input  wire                    sys_clk,
   input  wire                    rst,
   input  wire                    clk_en,
   // Wishbone classic slave
   input  wire                    wb_cyc_i,
   input  wire                    wb_stb_i,
   input  wire                    wb_we_i,
   input  wire [7:0]              wb_adr_i,
   input  wire [3:0]              wb_sel_i,
   input  wire [31:0]             wb_dat_i,
   output wire [31:0]             wb_dat_o,
   output wire                    wb_ack_o,
   // Device state
   input  wire                    remote_mode,
   input  wire [CHANNELS-1:0]     motor_moving,
   // Per-channel outputs to motion logic and drivers
   output wire [CHANNELS-1:0]     limit_switch_cw_force,
   output wire [CHANNELS-1:0]     limit_switch_ccw_force,
   output wire [CHANNELS-1:0]     holdoff_out,
   output wire [2*CHANNELS-1:0]   accel_profile_field,
   output wire [2*CHANNELS-1:0]   pulse_format_field
);

   reg  [CHANNELS-1:0]    en_reg;
   reg  [2*CHANNELS-1:0]  hd_reg;
   reg  [2*CHANNELS-1:0]  ac_reg;
   reg  [2*CHANNELS-1:0]  pl_reg;
   reg  [CHANNELS-1:0]    hold_pin_reg;
   reg  [CHANNELS-1:0]    hold_pin_next;
   reg  [CH_BITS-1:0]     query_ch_reg;
   reg                    ack_reg;
   reg  [31:0]            dat_reg;
   reg  [31:0]            dat_next;
   reg                    ignored_reg;

   wire                   req;
   wire                   wr_take;
   wire [CH_BITS-1:0]     cmd_ch;
   wire                   cmd_en;
   wire [1:0]             cmd_hd;
   wire [1:0]             cmd_ac;
   wire [1:0]             cmd_pl;
   wire                   cmd_hold_on;
   wire                   cfg_valid;
   wire                   cfg_hit;
   wire                   hold_hit;
   wire                   q_en;
   wire [1:0]             q_hd;
   wire [1:0]             q_ac;
   wire [1:0]             q_pl;

   integer i;

   assign req     = wb_cyc_i & wb_stb_i;
   // Write takes effect on the edge where the master sees ack
   assign wr_take = req & ack_reg & wb_we_i & wb_sel_i[0];

   assign cmd_ch      = wb_dat_i[`MBC_CH_LSB +: CH_BITS];
   assign cmd_en      = wb_dat_i[`MBC_EN_BIT];
   assign cmd_hd      = wb_dat_i[`MBC_HD_LSB +: 2];
   assign cmd_ac      = wb_dat_i[`MBC_AC_LSB +: 2];
   assign cmd_pl      = wb_dat_i[`MBC_PL_LSB +: 2];
   assign cmd_hold_on = wb_dat_i[`MBC_HOLD_ON_BIT];

   // Undefined accel or pulse codes would leave a generator unset
   assign cfg_valid = (cmd_ac != 2'h3) & (cmd_pl != 2'h3);
   assign cfg_hit   = wr_take & (wb_adr_i == `MBC_ADDR_CFG_SET);
   assign hold_hit  = wr_take & (wb_adr_i == `MBC_ADDR_HOLD_SW);

   // Configuration storage
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         en_reg       <= {CHANNELS{`MBC_RST_EN}};
         hd_reg       <= {CHANNELS{`MBC_RST_HD}};
         ac_reg       <= {CHANNELS{`MBC_RST_AC}};
         pl_reg       <= {CHANNELS{`MBC_RST_PL}};
         query_ch_reg <= {CH_BITS{1'b0}};
         ignored_reg  <= 1'b0;
      end else if (clk_en) begin
         if (cfg_hit) begin
            if (remote_mode && cfg_valid) begin
               en_reg[cmd_ch]        <= cmd_en;
               hd_reg[cmd_ch*2 +: 2] <= cmd_hd;
               ac_reg[cmd_ch*2 +: 2] <= cmd_ac;
               pl_reg[cmd_ch*2 +: 2] <= cmd_pl;
               ignored_reg           <= 1'b0;
            end else begin
               ignored_reg <= 1'b1;
            end
         end
         if (hold_hit) begin
            if (remote_mode) begin
               ignored_reg <= 1'b0;
               // Same field as the set command, so both views agree
               if (cmd_hold_on) begin
                  hd_reg[cmd_ch*2 +: 2] <= `MBC_HD_SUPPRESS;
               end else if (hd_reg[cmd_ch*2 +: 2] == `MBC_HD_SUPPRESS)
               begin
                  hd_reg[cmd_ch*2 +: 2] <= `MBC_HD_STOPPED;
               end
            end else begin
               ignored_reg <= 1'b1;
            end
         end
         if (wr_take && (wb_adr_i == `MBC_ADDR_QUERY_CH)) begin
            query_ch_reg <= wb_dat_i[CH_BITS-1:0];
         end
      end
   end

   // Hold-off pin level per channel
   always @* begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
         case (hd_reg[i*2 +: 2])
            `MBC_HD_STOPPED:    hold_pin_next[i] = ~motor_moving[i];
            `MBC_HD_SUPPRESS:   hold_pin_next[i] = 1'b0;
            // Inverted sense: high enables excitation while running
            `MBC_HD_EXCITE_RUN: hold_pin_next[i] = motor_moving[i];
            `MBC_HD_ALWAYS:     hold_pin_next[i] = 1'b1;
            default:            hold_pin_next[i] = 1'b0;
         endcase
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hold_pin_reg <= {CHANNELS{1'b0}};
      end else if (clk_en) begin
         hold_pin_reg <= hold_pin_next;
      end
   end

   assign holdoff_out            = hold_pin_reg;
   // Disabled channel looks like both limit switches are hit
   assign limit_switch_cw_force  = ~en_reg;
   assign limit_switch_ccw_force = ~en_reg;
   assign accel_profile_field    = ac_reg;
   assign pulse_format_field     = pl_reg;

   // Query view of the selected channel
   assign q_en = en_reg[query_ch_reg];
   assign q_hd = hd_reg[query_ch_reg*2 +: 2];
   assign q_ac = ac_reg[query_ch_reg*2 +: 2];
   assign q_pl = pl_reg[query_ch_reg*2 +: 2];

   // Read mux; unmapped addresses read zero and still ack
   always @* begin
      dat_next = 32'h0000_0000;
      case (wb_adr_i)
         `MBC_ADDR_QUERY_CH: begin
            dat_next[CH_BITS-1:0] = query_ch_reg;
         end
         `MBC_ADDR_QUERY_DATA: begin
            dat_next[`MBC_Q_EN_LSB +: 4] = {3'h0, q_en};
            dat_next[`MBC_Q_HD_LSB +: 4] = {2'h0, q_hd};
            dat_next[`MBC_Q_AC_LSB +: 4] = {2'h0, q_ac};
            dat_next[`MBC_Q_PL_LSB +: 4] = {2'h0, q_pl};
         end
         `MBC_ADDR_STATUS: begin
            dat_next[0] = remote_mode;
            dat_next[1] = ignored_reg;
         end
         default: begin
            dat_next = 32'h0000_0000;
         end
      endcase
   end

   // One wait state: ack rises the cycle after the request appears
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         ack_reg <= req & ~ack_reg;
         if (req && !ack_reg && !wb_we_i) begin
            dat_reg <= dat_next;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

endmodule

// ===== core/mbc_consts.vh
// Purpose: Constants for the per-channel basic motor configuration block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses of aligned words
`ifndef MBC_CONSTS_VH
`define MBC_CONSTS_VH

// Register offsets
`define MBC_ADDR_CFG_SET      8'h00
`define MBC_ADDR_HOLD_SW      8'h04
`define MBC_ADDR_QUERY_CH     8'h08
`define MBC_ADDR_QUERY_DATA   8'h0c
`define MBC_ADDR_STATUS       8'h10

// Command word field positions
`define MBC_CH_LSB            0
`define MBC_EN_BIT            4
`define MBC_HD_LSB            8
`define MBC_AC_LSB            12
`define MBC_PL_LSB            16
`define MBC_HOLD_ON_BIT       4

// Query reply nibble positions (enable, hold-off, accel, pulse)
`define MBC_Q_EN_LSB          12
`define MBC_Q_HD_LSB          8
`define MBC_Q_AC_LSB          4
`define MBC_Q_PL_LSB          0

// Hold-off modes
`define MBC_HD_STOPPED        2'h0
`define MBC_HD_SUPPRESS       2'h1
`define MBC_HD_EXCITE_RUN     2'h2
`define MBC_HD_ALWAYS         2'h3

// Acceleration profiles and pulse formats
`define MBC_AC_CONST          2'h0
`define MBC_AC_TRAPEZOID      2'h1
`define MBC_AC_S_SHAPE        2'h2
`define MBC_PL_CW_CCW         2'h0
`define MBC_PL_PULSE_DIR_A    2'h1
`define MBC_PL_PULSE_DIR_B    2'h2

// Reset values of every channel
`define MBC_RST_EN            1'h1
`define MBC_RST_HD            2'h0
`define MBC_RST_AC            2'h1
`define MBC_RST_PL            2'h0

`endif

// ===== verification/mbc_checker.sv
// Purpose: Bus and output checks on the configuration block
// Assumes: clk_en held high
// Notes:   Fields may only move on a write
`timescale 1ns/1ps
module mbc_checker #(parameter CHANNELS = 16) (
   input wire                  sys_clk,
   input wire                  rst,
   input wire                  wb_cyc_i,
   input wire                  wb_stb_i,
   input wire                  wb_ack_o,
   input wire                  remote_mode,
   input wire [CHANNELS-1:0]   motor_moving,
   input wire [CHANNELS-1:0]   limit_switch_cw_force,
   input wire [CHANNELS-1:0]   limit_switch_ccw_force,
   input wire [CHANNELS-1:0]   holdoff_out,
   input wire [2*CHANNELS-1:0] accel_profile_field,
   input wire [2*CHANNELS-1:0] pulse_format_field
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
   chk_ack_cause: assert property ($rose(wb_ack_o)
      |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("stray ack");
   chk_lim_pair: assert property (
      limit_switch_cw_force == limit_switch_ccw_force)
      else $error("limits differ");
   chk_acc_legal: assert property ((accel_profile_field &
      (accel_profile_field >> 1) & {CHANNELS{2'h1}}) == 0)
      else $error("accel 3");
   chk_pl_legal: assert property ((pulse_format_field &
      (pulse_format_field >> 1) & {CHANNELS{2'h1}}) == 0)
      else $error("pulse 3");
   chk_cfg_write: assert property (!$stable(accel_profile_field) ||
      !$stable(pulse_format_field) || !$stable(limit_switch_cw_force)
      |-> $past(wb_ack_o)) else $error("field moved");
   chk_hold_cause: assert property ($changed(holdoff_out)
      |-> $past(wb_ack_o, 2) || $past(rst, 2) ||
      $past(motor_moving) != $past(motor_moving, 2))
      else $error("holdoff moved");
   chk_local_hold: assert property (
      !$past(remote_mode) && !$past(remote_mode, 2)
      |-> $stable(accel_profile_field) && $stable(pulse_format_field)
      && $stable(limit_switch_cw_force)) else $error("local write");
endmodule
bind mbc_basic_config mbc_checker #(.CHANNELS(CHANNELS)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .remote_mode(remote_mode),
   .motor_moving(motor_moving), .holdoff_out(holdoff_out),
   .limit_switch_cw_force(limit_switch_cw_force),
   .limit_switch_ccw_force(limit_switch_ccw_force),
   .accel_profile_field(accel_profile_field),
   .pulse_format_field(pulse_format_field));

// ===== verification/mbc_host.sv
// Purpose: Host issuing commands as Wishbone words
// Assumes: Slave answers with one ack pulse
// Notes:   Released lines are inverted so stale data cannot pass
`timescale 1ns/1ps
`include "mbc_consts.vh"
module mbc_host (
   input wire        sys_clk,
   input wire        wb_ack_o,
   input wire [31:0] wb_dat_o,
   output reg        wb_cyc_i,
   output reg        wb_stb_i,
   output reg        wb_we_i,
   output reg [7:0]  wb_adr_i,
   output reg [3:0]  wb_sel_i,
   output reg [31:0] wb_dat_i
);
   initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
   task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q);
      begin
         @(posedge sys_clk);
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i}
            <= {2'h3, w, a, 4'hf, d};
         // Wait for ack however long; only the bench watchdog ends a hang
         @(posedge sys_clk);
         while (wb_ack_o !== 1'h1) @(posedge sys_clk);
         q = wb_dat_o;
         {wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} <= {2'h0, ~a, ~d};
      end
   endtask
   task set_cfg(input [3:0] ch, input en, input [1:0] hd, ac, pl);
      reg [31:0] q;
      xfer(`MBC_ADDR_CFG_SET, 1'h1, {14'h0, pl, 2'h0, ac, 2'h0, hd,
         3'h0, en, ch}, q);
   endtask
   task hold_sw(input [3:0] ch, input on);
      reg [31:0] q;
      xfer(`MBC_ADDR_HOLD_SW, 1'h1, {27'h0, on, ch}, q);
   endtask
   task query(input [3:0] ch, output [15:0] r);
      reg [31:0] q;
      begin
         xfer(`MBC_ADDR_QUERY_CH, 1'h1, {28'h0, ch}, q);
         xfer(`MBC_ADDR_QUERY_DATA, 1'h0, 32'h0, q);
         r = q[15:0];
      end
   endtask
endmodule

// ===== verification/motor_channel_basic_config_tb.sv
// Purpose: Self-checking bench for the configuration block
// Assumes: Host model drives the register bus
// Notes:   clk_en stays high throughout
`timescale 1ns/1ps
`include "mbc_consts.vh"
module motor_channel_basic_config_tb;
   reg         sys_clk, rst, remote_mode;
   reg  [15:0] motor_moving, r;
   reg  [31:0] q;
   wire        cyc, stb, we, ack;
   wire [7:0]  adr;
   wire [3:0]  sel;
   wire [31:0] wdat, rdat, accel, pulse;
   wire [15:0] cw, ccw, hold;
   integer     bad_count, cmp_count, i, m;
   mbc_basic_config dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .remote_mode(remote_mode), .motor_moving(motor_moving),
      .limit_switch_cw_force(cw), .limit_switch_ccw_force(ccw),
      .holdoff_out(hold), .accel_profile_field(accel),
      .pulse_format_field(pulse));
   mbc_host host (.sys_clk(sys_clk), .wb_ack_o(ack), .wb_dat_o(rdat),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat));
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   task check(input string nm, input [31:0] exp, got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
         end
      end
   endtask
   task t_codes;
      for (i = 0; i < 4; i = i + 1) begin
         host.set_cfg(4'hf, i[0], i[1:0], 2'(i % 3), 2'((i + 1) % 3));
         host.query(4'hf, r);
         check("query", (i % 2) * 4096 + i * 256 + (i % 3) * 16 +
            (i + 1) % 3, {16'h0, r});
         check("accel", i % 3, accel[31:30]);
         check("pulse", (i + 1) % 3, pulse[31:30]);
         check("limits", i[0] ? 0 : 3, {cw[15], ccw[15]});
      end
   endtask
   task t_hold;
      for (m = 0; m < 4; m = m + 1) begin
         host.set_cfg(4'h0, 1'h1, m[1:0], 2'h1, 2'h0);
         for (i = 0; i < 2; i = i + 1) begin
            motor_moving[0] <= i[0];
            repeat (3) @(posedge sys_clk);
            check("holdoff", m == 3 || (m != 1 && i[0] == (m == 2)),
               hold[0]);
         end
         motor_moving[0] <= 1'h0;
      end
   endtask
   task t_switch;
      begin
         host.hold_sw(4'h7, 1'h1);
         host.query(4'h7, r);
         check("switch on", 32'h1110, {16'h0, r});
         host.hold_sw(4'h7, 1'h0);
         host.query(4'h7, r);
         check("switch off", 32'h1010, {16'h0, r});
      end
   endtask
   task t_local;
      begin
         remote_mode <= 1'h0;
         host.set_cfg(4'h4, 1'h0, 2'h3, 2'h2, 2'h2);
         host.hold_sw(4'h4, 1'h1);
         host.query(4'h4, r);
         check("local", 32'h1010, {16'h0, r});
         host.xfer(`MBC_ADDR_STATUS, 1'h0, 32'h0, q);
         check("status", 32'h2, q);
         remote_mode <= 1'h1;
         // Undefined accel code must leave the channel untouched
         host.set_cfg(4'h4, 1'h1, 2'h2, 2'h3, 2'h0);
         host.query(4'h4, r);
         check("refused", 32'h1010, {16'h0, r});
         host.set_cfg(4'h4, 1'h1, 2'h2, 2'h1, 2'h0);
         host.hold_sw(4'h4, 1'h0);
         host.query(4'h4, r);
         check("off keeps", 32'h1210, {16'h0, r});
      end
   endtask
   task conclude;
      begin
         $display("compares %0d, mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      {bad_count, cmp_count, rst, remote_mode, motor_moving} = {65'h1, 17'h0};
      repeat (16) @(posedge sys_clk);
      {rst, remote_mode} <= 2'h1;
      host.query(4'h5, r);
      check("reset", 32'h1010, {16'h0, r});
      check("reset accel", 32'h55555555, accel);
      t_codes;
      t_hold;
      t_switch;
      t_local;
      conclude;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count = bad_count + 1;
      conclude;
   end
endmodule
